// >>> logic/scpc_top.sv
// Purpose: Smart card pad parallel access, supply gating and deactivation
// Assumes: Pad inputs and card presence are synchronous to CLK_SYS
// Notes: Open-drain pins are output and enable pairs
//
// Added by the designer: the AXI4-Lite register port.

`timescale 1ns/1ps

// Functional notes
// - Bit 5 reads/writes programming-voltage pad
// - Bit 4 reads/writes function-code pad
// - Bit 3 reads/writes card data pad
// - Bit 2 reads/writes card clock pad
// - Bit 1 reads/writes card reset pad
// - Bit 0 clear masks regulator select
// - Bit 0 set passes regulator select
// - Second interface has no auxiliary pads
// - Block works only with power bit set, except aux pads, which follow their drive bits
// - Deactivate: reset low, lines low, power off
// - Reset or unpowered: lines low, power off
// - Reception blocked while card reset low
// - Reset fall mid-byte discards partial character, except in loopback
// - Card removal triggers automatic deactivation
// - Removal shutdown raises general-purpose interrupt
// - Presence high holds interface control reset
// - Fast open-drain drives high one cycle
module scpc_top import scpc_pkg::*; #(
   parameter bit HAS_AUX_PADS = 1'b1 // Zero for the second card interface
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic CLK_EN,
   input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [AXI_DW-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [AXI_DW-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [NPAD-1:0] PAD_I,
   output logic [NPAD-1:0] PAD_O,
   output logic [NPAD-1:0] PAD_OE,
   output logic [NPAD-1:0] PAD_PULL_UP,
   output logic [NPAD-1:0] PAD_PULL_DN,
   input wire logic CARD_PRESENT_N,
   output logic SUPPLY_HIGH_ENABLE_N_O,
   output logic SUPPLY_HIGH_ENABLE_N_OE,
   output logic SUPPLY_LOW_ENABLE_N_O,
   output logic SUPPLY_LOW_ENABLE_N_OE,
   input wire logic RX_BUSY,
   output logic RX_ENABLE,
   output logic RX_DISCARD,
   output logic GPIO_IRQ
);

   // Bus slave state
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [AXI_DW-1:0] rdata_ff;
   logic [AXI_AW-1:0] waddr_ff; // Held write address
   logic [AXI_DW-1:0] wdata_ff; // Held write data
   logic [3:0] wstrb_ff;
   logic wr_go; // Both halves held, commit this cycle
   logic wr_lo, wr_hi; // Byte lanes 0 and 1 enabled

   // Control registers
   logic block_power_ff; // Card block power bit
   logic loopback_ff;
   logic [1:0] reg_select_ff; // Regulator select field
   logic session_ff; // Interface control session bit
   logic supply_gate_ff; // Parallel bit 0
   logic [NPAD-1:0] drive_ff; // Pad drive bits
   logic [CFG_W-1:0] cfg_ff [NPAD]; // Pad config fields
   logic [NPAD-1:0] sense_ff; // Sampled pad inputs
   logic removal_ff; // Sticky removal flag
   logic auto_ff; // Sequence started by removal

   // Sequencer
   scpc_state_t state_ff, nxt_state;
   logic [STEP_W-1:0] step_ff;
   logic step_done;

   // Pad outputs and receive control
   logic [NPAD-1:0] pad_o_ff, pad_oe_ff, prev_d_ff, pu_ff, pd_ff;
   logic [NPAD-1:0] nxt_o, nxt_oe, d_val, force_low, pad_exists;
   logic hi_n_oe_ff, lo_n_oe_ff;
   logic rx_en_ff, rx_drop_ff, rst_level_ff;
   logic rst_level;

   assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
   assign wr_lo = wr_go && wstrb_ff[0];
   assign wr_hi = wr_go && wstrb_ff[1];
   assign step_done = (step_ff == STEP_W'(DEACT_STEP_CYC - 1));

   // Address decode: known register word
   function automatic logic addr_ok(input logic [AXI_AW-1:0] a);
      logic ok;
      ok = (a == ADDR_BLOCK_CTRL) || (a == ADDR_POWER_CTRL) || (a == ADDR_IFACE_CTRL)
         || (a == ADDR_STATUS) || (a == ADDR_PAD_PAR);
      for (int k = 0; k < NPAD; k++) begin
         if (a == ADDR_PAD_CFG0 + AXI_AW'(k) * ADDR_PAD_STEP) begin
            ok = 1'b1;
         end
      end
      return ok;
   endfunction

   // Write channel: take address and data in either order
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         waddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
      end else if (CLK_EN) begin
         if (S_AXI_AWVALID && awready_ff) begin
            waddr_ff <= S_AXI_AWADDR;
            awready_ff <= 1'b0;
         end
         if (S_AXI_WVALID && wready_ff) begin
            wdata_ff <= S_AXI_WDATA;
            wstrb_ff <= S_AXI_WSTRB;
            wready_ff <= 1'b0;
         end
         if (wr_go) begin
            // Response one cycle after both halves are held
            bvalid_ff <= 1'b1;
            bresp_ff <= addr_ok(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_ff && S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // Read channel: data one cycle after address
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rresp_ff <= RESP_OKAY;
         rdata_ff <= '0;
      end else if (CLK_EN) begin
         if (S_AXI_ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rresp_ff <= addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            rdata_ff <= '0; // Reserved and unmapped read zero
            unique case (S_AXI_ARADDR)
               ADDR_BLOCK_CTRL: begin
                  rdata_ff[BLK_POWER_BIT] <= block_power_ff;
                  rdata_ff[BLK_LOOPBACK_BIT] <= loopback_ff;
               end
               ADDR_POWER_CTRL: rdata_ff[1:0] <= reg_select_ff;
               ADDR_IFACE_CTRL: rdata_ff[ICR_SESSION_BIT] <= session_ff;
               ADDR_STATUS: begin
                  rdata_ff[STAT_REMOVAL_BIT] <= removal_ff;
                  rdata_ff[STAT_PRESENT_BIT] <= !CARD_PRESENT_N;
                  rdata_ff[STAT_STATE_LSB +: 2] <= state_ff;
               end
               ADDR_PAD_PAR: begin
                  // Upper bits stay zero
                  rdata_ff[PAR_SUPPLY_GATE] <= supply_gate_ff;
                  rdata_ff[PAR_PAD_LSB +: NPAD] <= sense_ff & pad_exists;
               end
               default: begin
                  for (int k = 0; k < NPAD; k++) begin
                     if (S_AXI_ARADDR == ADDR_PAD_CFG0 + AXI_AW'(k) * ADDR_PAD_STEP) begin
                        rdata_ff[CFG_LSB +: CFG_W] <= cfg_ff[k];
                        rdata_ff[CFG_SENSE_BIT] <= sense_ff[k] & pad_exists[k];
                        rdata_ff[CFG_DRIVE_BIT] <= drive_ff[k];
                     end
                  end
               end
            endcase
         end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   // Block control and regulator select
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         block_power_ff <= 1'b0;
         loopback_ff <= 1'b0;
         reg_select_ff <= REG_SEL_OFF;
      end else if (CLK_EN) begin
         if (wr_lo && waddr_ff == ADDR_BLOCK_CTRL) begin
            block_power_ff <= wdata_ff[BLK_POWER_BIT];
            loopback_ff <= wdata_ff[BLK_LOOPBACK_BIT];
         end
         if (wr_lo && waddr_ff == ADDR_POWER_CTRL) begin
            reg_select_ff <= wdata_ff[1:0];
         end
      end
   end

   // Interface control session bit, forced clear when card absent
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         session_ff <= 1'b0;
      end else if (CLK_EN) begin
         if (CARD_PRESENT_N || !block_power_ff) begin
            session_ff <= 1'b0;
         end else if (wr_lo && waddr_ff == ADDR_IFACE_CTRL) begin
            session_ff <= wdata_ff[ICR_SESSION_BIT];
         end
      end
   end

   // Parallel register: supply gate and pad drive bits
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         supply_gate_ff <= 1'b0;
         drive_ff <= '0;
      end else if (CLK_EN) begin
         if (wr_lo && waddr_ff == ADDR_PAD_PAR) begin
            // Bits above 5 are dropped
            supply_gate_ff <= wdata_ff[PAR_SUPPLY_GATE];
            drive_ff <= wdata_ff[PAR_PAD_LSB +: NPAD];
         end else begin
            for (int k = 0; k < NPAD; k++) begin
               if (wr_lo && waddr_ff == ADDR_PAD_CFG0 + AXI_AW'(k) * ADDR_PAD_STEP) begin
                  drive_ff[k] <= wdata_ff[CFG_DRIVE_BIT];
               end
            end
         end
      end
   end

   // Pad config words, loaded before parallel use
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         for (int k = 0; k < NPAD; k++) begin
            cfg_ff[k] <= '0;
         end
      end else if (CLK_EN) begin
         for (int k = 0; k < NPAD; k++) begin
            if (wr_hi && waddr_ff == ADDR_PAD_CFG0 + AXI_AW'(k) * ADDR_PAD_STEP) begin
               cfg_ff[k] <= wdata_ff[CFG_LSB +: CFG_W];
            end
         end
      end
   end

   // Deactivation sequencer next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_ACTIVE: begin
            // Software clear, removal or block off start the sequence
            if (!session_ff) begin
               nxt_state = ST_RST_LOW;
            end
         end
         ST_RST_LOW: begin
            if (step_done) begin
               nxt_state = ST_LINES_LOW;
            end
         end
         ST_LINES_LOW: begin
            if (step_done) begin
               nxt_state = ST_OFF;
            end
         end
         ST_OFF: begin
            if (session_ff) begin
               nxt_state = ST_ACTIVE;
            end
         end
      endcase
   end

   // Sequencer state, step timer and removal cause
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         state_ff <= ST_OFF;
         step_ff <= '0;
         auto_ff <= 1'b0;
      end else if (CLK_EN) begin
         state_ff <= nxt_state;
         step_ff <= (nxt_state != state_ff) ? '0 : step_ff + STEP_W'(1);
         if (state_ff == ST_ACTIVE && nxt_state == ST_RST_LOW) begin
            auto_ff <= CARD_PRESENT_N;
         end else if (state_ff == ST_OFF) begin
            auto_ff <= 1'b0;
         end
      end
   end

   // Sticky removal flag, write one to clear, set wins
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         removal_ff <= 1'b0;
      end else if (CLK_EN) begin
         if (state_ff == ST_LINES_LOW && step_done && auto_ff) begin
            removal_ff <= 1'b1;
         end else if (wr_lo && waddr_ff == ADDR_STATUS && wdata_ff[STAT_REMOVAL_BIT]) begin
            removal_ff <= 1'b0;
         end
      end
   end

   // Per-pad drive, enables and fast open-drain pulse
   generate
      for (genvar i = 0; i < NPAD; i++) begin : g_pad
         assign pad_exists[i] = HAS_AUX_PADS || !PAD_AUX_MASK[i];
         // Reset pad low from first step, clock and data from second
         if (i == PAD_RST) begin : g_rst
            assign force_low[i] = (state_ff != ST_ACTIVE) || !block_power_ff;
         end else if (i == PAD_CLK || i == PAD_DATA) begin : g_line
            assign force_low[i] = state_ff[1] || !block_power_ff;
         end else begin : g_aux
            assign force_low[i] = 1'b0;
         end
         assign d_val[i] = drive_ff[i];

         always_comb begin
            nxt_o[i] = 1'b0;
            nxt_oe[i] = 1'b0;
            if (!pad_exists[i]) begin
               nxt_oe[i] = 1'b0;
            end else if (force_low[i]) begin
               nxt_oe[i] = 1'b1;
            end else if (!cfg_ff[i][CFG_OUT_EN]) begin
               nxt_oe[i] = 1'b0;
            end else if (cfg_ff[i][CFG_OPEN_DRAIN]) begin
               nxt_oe[i] = !d_val[i];
            end else if (cfg_ff[i][CFG_FAST_OD]) begin
               // High driven only on the cycle after a rise
               nxt_o[i] = d_val[i];
               nxt_oe[i] = !d_val[i] || !prev_d_ff[i];
            end else begin
               nxt_o[i] = d_val[i];
               nxt_oe[i] = 1'b1;
            end
         end

         // Registered pad pins and sampled input
         always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
               pad_o_ff[i] <= 1'b0;
               pad_oe_ff[i] <= PAD_OE_RST[i];
               prev_d_ff[i] <= 1'b0;
               pu_ff[i] <= 1'b0;
               pd_ff[i] <= 1'b0;
               sense_ff[i] <= 1'b0;
            end else if (CLK_EN) begin
               pad_o_ff[i] <= nxt_o[i];
               pad_oe_ff[i] <= nxt_oe[i];
               prev_d_ff[i] <= d_val[i] && !force_low[i];
               pu_ff[i] <= cfg_ff[i][CFG_PULL_UP] && pad_exists[i];
               pd_ff[i] <= cfg_ff[i][CFG_PULL_DN] && pad_exists[i];
               sense_ff[i] <= PAD_I[i] && cfg_ff[i][CFG_IN_EN];
            end
         end
      end
   endgenerate

   // Supply enables: active low, float high when off
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         hi_n_oe_ff <= 1'b0;
         lo_n_oe_ff <= 1'b0;
      end else if (CLK_EN) begin
         if (state_ff == ST_OFF || !supply_gate_ff || !block_power_ff) begin
            hi_n_oe_ff <= 1'b0;
            lo_n_oe_ff <= 1'b0;
         end else begin
            hi_n_oe_ff <= (reg_select_ff == REG_SEL_HIGH);
            lo_n_oe_ff <= (reg_select_ff == REG_SEL_LOW);
         end
      end
   end

   // Reset line level seen on the wire
   assign rst_level = pad_oe_ff[PAD_RST] ? pad_o_ff[PAD_RST] : PAD_I[PAD_RST];

   // Receive gating and partial character discard
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rst_level_ff <= 1'b0;
         rx_en_ff <= 1'b0;
         rx_drop_ff <= 1'b0;
      end else if (CLK_EN) begin
         rst_level_ff <= rst_level;
         rx_en_ff <= rst_level && block_power_ff;
         rx_drop_ff <= rst_level_ff && !rst_level && RX_BUSY && !loopback_ff;
      end
   end

   // Output wiring from flip-flops, supply enable pin levels tied low
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY = wready_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RRESP = rresp_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign PAD_O = pad_o_ff;
   assign PAD_OE = pad_oe_ff;
   assign PAD_PULL_UP = pu_ff;
   assign PAD_PULL_DN = pd_ff;
   assign SUPPLY_HIGH_ENABLE_N_O = 1'b0;
   assign SUPPLY_HIGH_ENABLE_N_OE = hi_n_oe_ff;
   assign SUPPLY_LOW_ENABLE_N_O = 1'b0;
   assign SUPPLY_LOW_ENABLE_N_OE = lo_n_oe_ff;
   assign RX_ENABLE = rx_en_ff;
   assign RX_DISCARD = rx_drop_ff;
   assign GPIO_IRQ = removal_ff;

endmodule

// >>> logic/scpc_pkg.sv
// Purpose: Shared constants for the smart card pad and power control block
// Assumes: AXI4-Lite slave with 8-bit byte address and 32-bit data
// Notes: Pad index order is reset, clock, data, function code, prog voltage
package scpc_pkg;

   // Bus widths
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;

   // Register byte addresses
   localparam logic [7:0] ADDR_BLOCK_CTRL = 8'h00; // Block power and loopback
   localparam logic [7:0] ADDR_POWER_CTRL = 8'h04; // Regulator select field
   localparam logic [7:0] ADDR_IFACE_CTRL = 8'h08; // Session control
   localparam logic [7:0] ADDR_STATUS = 8'h0c; // Removal flag and state
   localparam logic [7:0] ADDR_PAD_CFG0 = 8'h10; // First of five pad configs
   localparam logic [7:0] ADDR_PAD_STEP = 8'h04; // Spacing of pad configs
   localparam logic [7:0] ADDR_PAD_PAR = 8'ha4; // Parallel pad register

   // Pads
   localparam int NPAD = 5;
   localparam int PAD_RST = 0;
   localparam int PAD_CLK = 1;
   localparam int PAD_DATA = 2;
   localparam int PAD_FCB = 3;
   localparam int PAD_SPU = 4;

   // Parallel register fields
   localparam int PAR_SUPPLY_GATE = 0; // Card supply gate bit
   localparam int PAR_PAD_LSB = 1; // Pad bits start here, reset pad first
   localparam int PAR_USED_W = 6; // Bits 5:0, rest read zero

   // Pad config fields
   localparam int CFG_LSB = 8;
   localparam int CFG_W = 6;
   localparam int CFG_PULL_DN = 0; // Offsets inside the config field
   localparam int CFG_PULL_UP = 1;
   localparam int CFG_OPEN_DRAIN = 2;
   localparam int CFG_FAST_OD = 3;
   localparam int CFG_OUT_EN = 4;
   localparam int CFG_IN_EN = 5;
   localparam int CFG_SENSE_BIT = 1; // Sampled input bit in a pad config word
   localparam int CFG_DRIVE_BIT = 0; // Drive bit in a pad config word

   // Control fields
   localparam int BLK_POWER_BIT = 0;
   localparam int BLK_LOOPBACK_BIT = 1;
   localparam int ICR_SESSION_BIT = 0;
   localparam int STAT_REMOVAL_BIT = 0;
   localparam int STAT_PRESENT_BIT = 1;
   localparam int STAT_STATE_LSB = 2;

   // Regulator select codes
   localparam logic [1:0] REG_SEL_OFF = 2'h0;
   localparam logic [1:0] REG_SEL_LOW = 2'h1; // Low supply voltage
   localparam logic [1:0] REG_SEL_HIGH = 2'h2; // High supply voltage

   // Reset values
   localparam logic [NPAD-1:0] PAD_OE_RST = 5'h07; // Reset, clock, data driven low
   localparam logic [NPAD-1:0] PAD_AUX_MASK = 5'h18; // Pads absent on second card

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Deactivation step timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int DEACT_STEP_NS = 1000; // Least time between sequence steps
   localparam int DEACT_STEP_CYC = (DEACT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STEP_W = 8;

   // Deactivation sequence states
   typedef enum logic [1:0] {
      ST_ACTIVE = 2'b00,
      ST_RST_LOW = 2'b01,
      ST_LINES_LOW = 2'b10,
      ST_OFF = 2'b11
   } scpc_state_t;

endpackage

// >>> bench/scpc_card_model.sv
// Purpose: Card side of the five pad wires
// Assumes: Block drive wins, then card drive, then pulls
// Notes: A line nobody holds toggles every cycle
`timescale 1ns/1ps
module scpc_card_model import scpc_pkg::*; (
   input wire logic clk,
   input wire logic [NPAD-1:0] pad_o,
   input wire logic [NPAD-1:0] pad_oe,
   input wire logic [NPAD-1:0] pull_up,
   input wire logic [NPAD-1:0] pull_dn,
   input wire logic [NPAD-1:0] card_en,
   input wire logic [NPAD-1:0] card_val,
   output logic [NPAD-1:0] pad_i
);
   logic flip_ff = 1'b0; // Unknown level stand-in
   // Changes each cycle so a float never reads steady
   always_ff @(posedge clk) begin
      flip_ff <= !flip_ff;
   end
   // Resolve each wire level
   always_comb begin
      for (int i = 0; i < NPAD; i++) begin
         if (pad_oe[i])
            pad_i[i] = pad_o[i];
         else if (card_en[i])
            pad_i[i] = card_val[i];
         else if (pull_up[i] || pull_dn[i])
            pad_i[i] = pull_up[i];
         else
            pad_i[i] = flip_ff;
      end
   end
endmodule

// >>> bench/scpc_props.sv
// Purpose: Port properties of the card pad and power block
// Assumes: Bound to every instance of the top module
// Notes: Drop order judged on supply falls with the card out
`timescale 1ns/1ps
module scpc_props import scpc_pkg::*; #(
   parameter bit HAS_AUX_PADS = 1'b1
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [NPAD-1:0] PAD_O,
   input wire logic [NPAD-1:0] PAD_OE,
   input wire logic CARD_PRESENT_N,
   input wire logic SUPPLY_HIGH_ENABLE_N_O,
   input wire logic SUPPLY_HIGH_ENABLE_N_OE,
   input wire logic SUPPLY_LOW_ENABLE_N_O,
   input wire logic SUPPLY_LOW_ENABLE_N_OE,
   input wire logic RX_ENABLE,
   input wire logic RX_DISCARD,
   input wire logic GPIO_IRQ
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   logic [7:0] gone_ff; // Cycles with card out, saturating
   // Count removal time
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST)
         gone_ff <= 8'h00;
      else if (!CARD_PRESENT_N)
         gone_ff <= 8'h00;
      else if (gone_ff != 8'hff)
         gone_ff <= gone_ff + 8'h01;
   end
   sequence rst_low_s;
      PAD_OE[PAD_RST] && !PAD_O[PAD_RST];
   endsequence
   sequence lines_low_s;
      PAD_OE[2:1] == 2'b11 && PAD_O[2:1] == 2'b00;
   endsequence
   property drop_order_p(logic oe);
      $fell(oe) && CARD_PRESENT_N |-> rst_low_s and lines_low_s;
   endproperty
   sup_pins_low_a: assert property (!SUPPLY_HIGH_ENABLE_N_O && !SUPPLY_LOW_ENABLE_N_O)
      else $error("supply enable pin driven high");
   one_supply_a: assert property (!(SUPPLY_HIGH_ENABLE_N_OE && SUPPLY_LOW_ENABLE_N_OE))
      else $error("both supplies enabled");
   low_order_a: assert property (drop_order_p(SUPPLY_LOW_ENABLE_N_OE))
      else $error("low supply dropped before lines");
   high_order_a: assert property (drop_order_p(SUPPLY_HIGH_ENABLE_N_OE))
      else $error("high supply dropped before lines");
   removal_start_a: assert property ($rose(CARD_PRESENT_N) |-> ##[1:4] rst_low_s)
      else $error("reset line not low after removal");
   removal_off_a: assert property (gone_ff == 8'h78 |-> !SUPPLY_LOW_ENABLE_N_OE
      && !SUPPLY_HIGH_ENABLE_N_OE)
      else $error("supply on with card out");
   irq_after_a: assert property ($rose(GPIO_IRQ) |-> rst_low_s and lines_low_s)
      else $error("removal flag before shutdown");
   rx_blocked_a: assert property (rst_low_s [*2] |-> !RX_ENABLE)
      else $error("reception open with reset low");
   discard_pulse_a: assert property (RX_DISCARD |-> !RX_ENABLE ##1 !RX_DISCARD)
      else $error("discard pulse malformed");
   aux_absent_a: assert property (!HAS_AUX_PADS |-> PAD_OE[4:3] == 2'b00)
      else $error("absent pad driven");
endmodule
bind scpc_top scpc_props #(.HAS_AUX_PADS(HAS_AUX_PADS)) scpc_props_inst (.CLK_SYS, .NRST,
   .PAD_O, .PAD_OE, .CARD_PRESENT_N, .SUPPLY_HIGH_ENABLE_N_O, .SUPPLY_HIGH_ENABLE_N_OE,
   .SUPPLY_LOW_ENABLE_N_O, .SUPPLY_LOW_ENABLE_N_OE, .RX_ENABLE, .RX_DISCARD, .GPIO_IRQ);

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the card pad and power block
// Assumes: Bench is bus master, card model on the pads
// Notes: Expected values reckoned here, never read back
`timescale 1ns/1ps
module tb_top;
   import scpc_pkg::*;
   logic clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pres_n = 0, busy = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd_v, v, rdata;
   logic awr, wrdy, arr, bv, rv, sh_o, sh_oe, sl_o, sl_oe, rx_en, disc, irq;
   logic [1:0] resp, bresp, rresp;
   logic [NPAD-1:0] pad_i, pad_o, pad_oe, pu, pd, card_en = 0, card_val = 0;
   int err_count = 0, comparisons = 0, n, hi = 0, h0, disc_n = 0;
   always #12.5 clk = !clk; // 40 MHz
   // Discard pulse count and fast drive-high count
   always @(posedge clk) begin
      disc_n <= disc_n + int'(disc);
      hi <= hi + int'(pad_oe[1] & pad_o[1]);
   end
   scpc_top scpc_top_inst (.CLK_SYS(clk), .NRST(nrst), .CLK_EN(1'b1), .S_AXI_AWADDR(awa),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
      .PAD_I(pad_i), .PAD_O(pad_o), .PAD_OE(pad_oe), .PAD_PULL_UP(pu), .PAD_PULL_DN(pd),
      .CARD_PRESENT_N(pres_n), .SUPPLY_HIGH_ENABLE_N_O(sh_o), .SUPPLY_HIGH_ENABLE_N_OE(sh_oe),
      .SUPPLY_LOW_ENABLE_N_O(sl_o), .SUPPLY_LOW_ENABLE_N_OE(sl_oe), .RX_BUSY(busy),
      .RX_ENABLE(rx_en), .RX_DISCARD(disc), .GPIO_IRQ(irq));
   scpc_card_model scpc_card_model_inst (.clk(clk), .pad_o(pad_o), .pad_oe(pad_oe),
      .pull_up(pu), .pull_dn(pd), .card_en(card_en), .card_val(card_val), .pad_i(pad_i));
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   // Bounded wait for a handshake signal
   task automatic wait_hi(ref logic s);
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (n > 100) begin
            err_count++;
            complete_run();
         end
      end while (s !== 1'b1);
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awr && !aw_ok)
            awv <= 1'b0;
         if (wrdy && !w_ok)
            wv <= 1'b0;
         aw_ok = aw_ok || awr;
         w_ok = w_ok || wrdy;
      end
      br <= 1'b1;
      wait_hi(bv);
      br <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      wait_hi(arr);
      arv <= 1'b0;
      rr <= 1'b1;
      wait_hi(rv);
      rd_v = rdata;
      resp = rresp;
      rr <= 1'b0;
   endtask
   task automatic cfg_all(input logic [31:0] c);
      for (int k = 0; k < NPAD; k++)
         wr(8'(ADDR_PAD_CFG0 + 4 * k), c);
   endtask
   initial begin
      void'($urandom(32'h34057741));
      tick(5);
      nrst <= 1'b1;
      chk("pad_oe", 32'(pad_oe), 32'(PAD_OE_RST));
      chk("outs", 32'({pad_o, sh_oe, sl_oe, rx_en, irq}), 0);
      rd(ADDR_PAD_PAR);
      chk("par_rst", rd_v, 0);
      wr(ADDR_BLOCK_CTRL, 1);
      cfg_all(32'h3000);
      wr(ADDR_IFACE_CTRL, 1);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         wr(ADDR_PAD_PAR, v);
         tick(3);
         chk("pad_o", 32'(pad_o), 32'(v[5:1]));
         rd(ADDR_PAD_PAR);
         chk("par_rd", rd_v, 32'(v[5:0]));
      end
      for (int s = 0; s < 4; s++)
         for (int g = 0; g < 2; g++) begin
            wr(ADDR_POWER_CTRL, s);
            wr(ADDR_PAD_PAR, 32'(g) | 32'h02);
            tick(3);
            chk("supply", 32'({sh_oe, sl_oe}), 32'({g == 1 && s == 2, g == 1 && s == 1}));
         end
      card_val <= 5'($urandom);
      card_en <= '1;
      cfg_all(32'h2200);
      tick(3);
      rd(ADDR_PAD_PAR);
      chk("par_sense", rd_v, 32'({card_val, 1'b1}));
      chk("pulls", 32'({pu, pd}), 32'h3e0);
      card_en <= '0;
      cfg_all(32'h3000);
      for (int lb = 0; lb < 2; lb++) begin
         wr(ADDR_BLOCK_CTRL, 32'(1 + 2 * lb));
         wr(ADDR_PAD_PAR, 32'h03);
         tick(3);
         chk("rx_en", 32'(rx_en), 1);
         busy <= 1'b1;
         h0 = disc_n;
         wr(ADDR_PAD_PAR, 32'h01);
         tick(5);
         chk("discard", {rx_en, 31'(disc_n - h0)}, 32'(lb == 0));
         busy <= 1'b0;
      end
      wr(ADDR_BLOCK_CTRL, 1);
      wr(ADDR_POWER_CTRL, 32'(REG_SEL_LOW));
      wr(ADDR_PAD_PAR, 32'h0f);
      tick(3);
      wr(ADDR_BLOCK_CTRL, 0);
      tick(3);
      chk("blk_off", 32'({sl_oe, rx_en, pad_oe[2:0], pad_o[2:0]}), 32'h38);
      rd(ADDR_IFACE_CTRL);
      chk("icr_off", rd_v, 0);
      wr(ADDR_BLOCK_CTRL, 1);
      tick(100);
      wr(ADDR_IFACE_CTRL, 1);
      tick(3);
      chk("sup_on", 32'(sl_oe), 1);
      wr(ADDR_IFACE_CTRL, 0);
      for (n = 0; sl_oe && n < 300; n++)
         @(posedge clk);
      chk("deact_len", 32'(n >= 2 * DEACT_STEP_CYC - 4 && n < 300), 1);
      rd(ADDR_STATUS);
      chk("state", 32'(rd_v[3:2]), 32'(ST_OFF));
      wr(ADDR_IFACE_CTRL, 1);
      wr(ADDR_PAD_PAR, 32'h0b);
      wr(8'(ADDR_PAD_CFG0 + 4), 32'h3800);
      h0 = hi;
      wr(ADDR_PAD_PAR, 32'h0f);
      tick(5);
      chk("fast_od", 32'({hi - h0, pad_oe[1]}), 32'h2);
      pres_n <= 1'b1;
      tick(120);
      chk("removed", 32'({irq, sh_oe, sl_oe, pad_o[2:0]}), 32'h20);
      rd(ADDR_STATUS);
      chk("status", 32'({rd_v[3:2], rd_v[0]}), 32'h7);
      wr(ADDR_IFACE_CTRL, 1);
      rd(ADDR_IFACE_CTRL);
      chk("icr_held", rd_v, 0);
      wr(ADDR_STATUS, 1);
      tick(2);
      chk("irq_clr", 32'(irq), 0);
      pres_n <= 1'b0;
      rd(8'h80);
      chk("unmapped", {resp, rd_v[29:0]}, {RESP_SLVERR, 30'h0});
      complete_run();
   end
endmodule
